// ---- src/msx_sfr.sv ----
// Added special-function registers: two extra interrupts, nibble port,
// strobe suppression, power control and the watchdog.
// Assumes the core drives register accesses synchronously on clk and acks service.
`timescale 1ns/1ps

module msx_sfr #(
  parameter int WDOG_BITS = msx_pkg::WDOG_TIMER_BITS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic nPor,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic bitWrEn,
  input wire logic [7:0] bitAddr,
  input wire logic bitWrVal,
  input wire logic sfrRdEn,
  input wire logic sfrRmw,
  output logic [7:0] sfrRdData_q,
  output logic sfrRdHit_q,
  input wire logic [3:0] portPinIn,
  output logic [3:0] portPinOut_q,
  output logic [3:0] portPinOe_q,
  input wire logic irqAAck,
  input wire logic irqBAck,
  input wire logic coreIrqWake,
  output logic irqAReq_q,
  output logic irqBReq_q,
  output logic irqAHigh_q,
  output logic irqBHigh_q,
  output logic [7:0] irqVector_q,
  input wire logic aleRaw,
  input wire logic extAccess,
  output logic aleOut_q,
  output logic cpuHalt_q,
  output logic deepSleep_q,
  output logic wdogReset_q
);

  // Merges a byte or bit write into a register image.
  function automatic logic [7:0] fMerge(input logic [7:0] addr, input logic [7:0] old);
    logic [7:0] mask;
    logic [7:0] val;
    mask = 8'h00;
    val = {8{bitWrVal}};
    if (sfrWrEn && sfrAddr == addr) begin
      mask = 8'hFF;
      val = sfrWrData;
    end else if (bitWrEn && addr[2:0] == 3'h0 && bitAddr[7:3] == addr[7:3]) begin
      mask = 8'h01 << bitAddr[2:0];
    end
    return (old & ~mask) | (val & mask);
  endfunction

  // True when a byte or bit write touches the register.
  function automatic logic fTouch(input logic [7:0] addr);
    return (sfrWrEn && sfrAddr == addr) ||
      (bitWrEn && addr[2:0] == 3'h0 && bitAddr[7:3] == addr[7:3]);
  endfunction

  // Prescaler divide ratio for a select code.
  function automatic logic [8:0] fDivide(input logic [2:0] sel);
    case (sel)
      3'h0: return 9'h002;
      3'h2: return 9'h004;
      3'h1: return 9'h008;
      3'h3: return 9'h010;
      3'h4: return 9'h020;
      3'h5: return 9'h040;
      3'h6: return 9'h080;
      default: return 9'h100;
    endcase
  endfunction

  logic [3:0] pinMeta_q, pinSync_q, pinPrev_q, portLatch_q, mcCnt_q;
  logic [7:0] irqCtrl_q, auxCtrl_q, wdogCtrl_q, preCnt_q;
  logic [7:0] irqNext, wdogNext, pconNext, pconRead;
  logic [1:0] userFlags_q;
  logic [WDOG_BITS-1:0] wdCnt_q;
  msx_pkg::msx_power_type power_q;
  logic coldStart_q;
  logic fallA, fallB, mcTick, wdCount, preTick, kickNow, wake;

  // Pin synchroniser; only the second stage and beyond are looked at.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta_q <= msx_pkg::RESET_PORT;
      pinSync_q <= msx_pkg::RESET_PORT;
      pinPrev_q <= msx_pkg::RESET_PORT;
    end else begin
      pinMeta_q <= portPinIn;
      pinSync_q <= pinMeta_q;
      pinPrev_q <= pinSync_q;
    end
  end

  assign fallA = pinPrev_q[msx_pkg::PIN_IRQ_A] && !pinSync_q[msx_pkg::PIN_IRQ_A];
  assign fallB = pinPrev_q[msx_pkg::PIN_IRQ_B] && !pinSync_q[msx_pkg::PIN_IRQ_B];
  // Pending flags: software write first, then service clear, then detection wins.
  always_comb begin
    irqNext = fMerge(msx_pkg::ADDR_AUX_IRQ_CTRL, irqCtrl_q);
    if (irqNext[msx_pkg::IRQ_A_EDGE_SELECT]) begin
      if (irqAAck) begin
        irqNext[msx_pkg::IRQ_A_PENDING] = 1'b0;
      end
      if (fallA) begin
        irqNext[msx_pkg::IRQ_A_PENDING] = 1'b1;
      end
    end else begin
      irqNext[msx_pkg::IRQ_A_PENDING] = !pinSync_q[msx_pkg::PIN_IRQ_A];
    end
    if (irqNext[msx_pkg::IRQ_B_EDGE_SELECT]) begin
      if (irqBAck) begin
        irqNext[msx_pkg::IRQ_B_PENDING] = 1'b0;
      end
      if (fallB) begin
        irqNext[msx_pkg::IRQ_B_PENDING] = 1'b1;
      end
    end else begin
      irqNext[msx_pkg::IRQ_B_PENDING] = !pinSync_q[msx_pkg::PIN_IRQ_B];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqCtrl_q <= msx_pkg::RESET_CTRL;
    end else begin
      irqCtrl_q <= irqNext;
    end
  end
  // Requests to the core, gated by enable, with priority level and vector.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqAReq_q <= 1'b0;
      irqBReq_q <= 1'b0;
      irqAHigh_q <= 1'b0;
      irqBHigh_q <= 1'b0;
      irqVector_q <= msx_pkg::VECTOR_NONE;
    end else begin
      irqAReq_q <= irqCtrl_q[msx_pkg::IRQ_A_PENDING] && irqCtrl_q[msx_pkg::IRQ_A_ENABLE];
      irqBReq_q <= irqCtrl_q[msx_pkg::IRQ_B_PENDING] && irqCtrl_q[msx_pkg::IRQ_B_ENABLE];
      irqAHigh_q <= irqCtrl_q[msx_pkg::IRQ_A_HIGH_PRIORITY];
      irqBHigh_q <= irqCtrl_q[msx_pkg::IRQ_B_HIGH_PRIORITY];
      irqVector_q <= (irqCtrl_q[msx_pkg::IRQ_A_PENDING] && irqCtrl_q[msx_pkg::IRQ_A_ENABLE]) ?
        msx_pkg::VECTOR_IRQ_A : (irqCtrl_q[msx_pkg::IRQ_B_PENDING] &&
        irqCtrl_q[msx_pkg::IRQ_B_ENABLE]) ? msx_pkg::VECTOR_IRQ_B : msx_pkg::VECTOR_NONE;
    end
  end

  // Quasi-bidirectional nibble port: a zero in the latch pulls the pin low.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      portLatch_q <= msx_pkg::RESET_PORT;
      portPinOut_q <= msx_pkg::RESET_PORT;
      portPinOe_q <= 4'h0;
    end else begin
      portLatch_q <= 4'(fMerge(msx_pkg::ADDR_NIBBLE_PORT, {4'hF, portLatch_q}));
      portPinOut_q <= portLatch_q;
      portPinOe_q <= ~portLatch_q;
    end
  end

  // Address strobe suppression, released during external accesses.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      auxCtrl_q <= msx_pkg::RESET_CTRL;
      aleOut_q <= 1'b0;
    end else begin
      auxCtrl_q <= fMerge(msx_pkg::ADDR_AUX_CTRL, auxCtrl_q);
      aleOut_q <= (auxCtrl_q[msx_pkg::STROBE_SUPPRESS] && !extAccess) ? 1'b0 : aleRaw;
    end
  end

  // Cold-start flag lives on the power-on reset only; the merge sits in a process
  // because the function also reads the bus strobes.
  always_comb begin
    pconNext = fMerge(msx_pkg::ADDR_POWER_CTRL, pconRead);
  end

  always_ff @(posedge clk or negedge nPor) begin
    if (!nPor) begin
      coldStart_q <= 1'b1;
    end else if (fTouch(msx_pkg::ADDR_POWER_CTRL)) begin
      coldStart_q <= pconNext[msx_pkg::COLD_START_FLAG];
    end
  end
  assign wake = coreIrqWake || irqAReq_q || irqBReq_q;
  // User flags and power mode; only a reset leaves sleep.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      userFlags_q <= 2'b00;
      power_q <= msx_pkg::PWR_RUN;
      cpuHalt_q <= 1'b0;
      deepSleep_q <= 1'b0;
    end else begin
      cpuHalt_q <= power_q == msx_pkg::PWR_HALT;
      deepSleep_q <= power_q == msx_pkg::PWR_SLEEP;
      userFlags_q <= pconNext[msx_pkg::USER_FLAG_HI:msx_pkg::USER_FLAG_LO];
      case (power_q)
        msx_pkg::PWR_RUN: begin
          if (fTouch(msx_pkg::ADDR_POWER_CTRL) && pconNext[msx_pkg::DEEP_SLEEP_REQUEST]) begin
            power_q <= msx_pkg::PWR_SLEEP;
          end else if (fTouch(msx_pkg::ADDR_POWER_CTRL) && pconNext[msx_pkg::CPU_HALT_REQUEST]) begin
            power_q <= msx_pkg::PWR_HALT;
          end
        end
        msx_pkg::PWR_HALT: begin
          if (wake) begin
            power_q <= msx_pkg::PWR_RUN;
          end
        end
        msx_pkg::PWR_SLEEP: begin
          power_q <= msx_pkg::PWR_SLEEP;
        end
        default: begin
          power_q <= msx_pkg::PWR_RUN;
        end
      endcase
    end
  end

  assign pconRead = {3'h0, coldStart_q, userFlags_q,
    power_q == msx_pkg::PWR_SLEEP, power_q == msx_pkg::PWR_HALT};

  // Machine-cycle divider feeding the watchdog prescaler.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mcCnt_q <= 4'h0;
    end else begin
      mcCnt_q <= (mcCnt_q == msx_pkg::MC_LAST) ? 4'h0 : mcCnt_q + 4'h1;
    end
  end

  assign mcTick = mcCnt_q == msx_pkg::MC_LAST;
  assign kickNow = mcTick && wdogCtrl_q[msx_pkg::WDOG_KICK];
  assign wdCount = mcTick && power_q != msx_pkg::PWR_SLEEP &&
    !(power_q == msx_pkg::PWR_HALT && !wdogCtrl_q[msx_pkg::WDOG_RUN_IN_HALT]);
  assign preTick = wdCount &&
    ({1'b0, preCnt_q} == fDivide(wdogCtrl_q[2:0]) - 9'h001);

  // Watchdog control; the kick bit clears itself once its machine cycle arrives.
  always_comb begin
    wdogNext = wdogCtrl_q;
    if (kickNow) begin
      wdogNext[msx_pkg::WDOG_KICK] = 1'b0;
    end
    wdogNext = fMerge(msx_pkg::ADDR_WDOG_CTRL, wdogNext);
    wdogNext[4:3] = 2'b00;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wdogCtrl_q <= msx_pkg::RESET_CTRL;
    end else begin
      wdogCtrl_q <= wdogNext;
    end
  end

  // Prescaler and timer; overflow while enabled asks for a system reset.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      preCnt_q <= 8'h00;
      wdCnt_q <= '0;
      wdogReset_q <= 1'b0;
    end else begin
      wdogReset_q <= 1'b0;
      if (kickNow) begin
        preCnt_q <= 8'h00;
        wdCnt_q <= '0;
      end else if (preTick) begin
        preCnt_q <= 8'h00;
        wdCnt_q <= wdCnt_q + 1'b1;
        wdogReset_q <= (&wdCnt_q) && wdogCtrl_q[msx_pkg::WDOG_RUN];
      end else if (wdCount) begin
        preCnt_q <= preCnt_q + 8'h01;
      end
    end
  end

  // Read port; the read-modify-write form of the port returns the latch.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfrRdData_q <= msx_pkg::RESET_READ;
      sfrRdHit_q <= 1'b0;
    end else begin
      sfrRdHit_q <= 1'b0;
      sfrRdData_q <= msx_pkg::RESET_READ;
      if (sfrRdEn) begin
        sfrRdHit_q <= 1'b1;
        case (sfrAddr)
          msx_pkg::ADDR_POWER_CTRL: sfrRdData_q <= pconRead;
          msx_pkg::ADDR_AUX_CTRL: sfrRdData_q <= auxCtrl_q;
          msx_pkg::ADDR_WDOG_CTRL: sfrRdData_q <= wdogCtrl_q;
          msx_pkg::ADDR_AUX_IRQ_CTRL: sfrRdData_q <= irqCtrl_q;
          msx_pkg::ADDR_NIBBLE_PORT: begin
            sfrRdData_q <= {4'hF, sfrRmw ? portLatch_q : pinSync_q};
          end
          default: sfrRdHit_q <= 1'b0;
        endcase
      end
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_edge_sets_pend: assert property (
    irqCtrl_q[msx_pkg::IRQ_A_EDGE_SELECT] && fallA && !fTouch(msx_pkg::ADDR_AUX_IRQ_CTRL)
      |=> irqCtrl_q[msx_pkg::IRQ_A_PENDING])
    else $error("Falling edge did not set pending flag A.");
  chk_level_follows_pin: assert property (
    !irqCtrl_q[msx_pkg::IRQ_B_EDGE_SELECT] && !fTouch(msx_pkg::ADDR_AUX_IRQ_CTRL)
      |=> irqCtrl_q[msx_pkg::IRQ_B_PENDING] == !$past(pinSync_q[msx_pkg::PIN_IRQ_B]))
    else $error("Level-mode pending flag B does not follow the pin.");
  chk_ack_clears_pend: assert property (
    irqCtrl_q[msx_pkg::IRQ_A_EDGE_SELECT] && irqAAck && !fallA &&
      !fTouch(msx_pkg::ADDR_AUX_IRQ_CTRL) |=> !irqCtrl_q[msx_pkg::IRQ_A_PENDING])
    else $error("Service did not clear pending flag A.");
  chk_req_needs_enable: assert property (
    irqBReq_q |-> $past(irqCtrl_q[msx_pkg::IRQ_B_ENABLE] && irqCtrl_q[msx_pkg::IRQ_B_PENDING]))
    else $error("Request B raised without enable and pending.");
  chk_strobe_gated: assert property (
    auxCtrl_q[msx_pkg::STROBE_SUPPRESS] && !extAccess |=> !aleOut_q)
    else $error("Address strobe toggled while suppressed.");
  chk_kick_clears_wdog: assert property (
    kickNow && !fTouch(msx_pkg::ADDR_WDOG_CTRL)
      |=> wdCnt_q == '0 && preCnt_q == 8'h00 && !wdogCtrl_q[msx_pkg::WDOG_KICK])
    else $error("Kick did not clear timer, prescaler and kick bit.");
  chk_halt_freezes_wdog: assert property (
    power_q == msx_pkg::PWR_HALT && !wdogCtrl_q[msx_pkg::WDOG_RUN_IN_HALT] && !kickNow
      |=> $stable(wdCnt_q) && $stable(preCnt_q))
    else $error("Watchdog advanced in halt without run-in-halt.");
  chk_timeout_enabled: assert property (
    wdogReset_q |-> $past(wdogCtrl_q[msx_pkg::WDOG_RUN]) && wdCnt_q == '0)
    else $error("Watchdog reset without enable or overflow.");
  chk_machine_cycle: assert property (
    mcTick |=> !mcTick [*8] ##1 !mcTick [*3] ##1 mcTick)
    else $error("Machine cycle is not twelve clocks.");
  chk_sleep_holds: assert property (
    power_q == msx_pkg::PWR_SLEEP |=> power_q == msx_pkg::PWR_SLEEP)
    else $error("Sleep left without reset.");

endmodule

// ---- src/msx_pkg.sv ----
// Constants shared by the system-extension register block.
// Assumes an 8-bit core that reaches these registers by byte and bit accesses.
package msx_pkg;
  // Register byte addresses on the internal register access.
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h87;
  localparam logic [7:0] ADDR_AUX_CTRL = 8'h8E;
  localparam logic [7:0] ADDR_WDOG_CTRL = 8'h8F;
  localparam logic [7:0] ADDR_AUX_IRQ_CTRL = 8'hC0;
  localparam logic [7:0] ADDR_NIBBLE_PORT = 8'hD8;

  // Field positions of the added interrupt control register.
  localparam int IRQ_B_HIGH_PRIORITY = 7;
  localparam int IRQ_B_ENABLE = 6;
  localparam int IRQ_B_PENDING = 5;
  localparam int IRQ_B_EDGE_SELECT = 4;
  localparam int IRQ_A_HIGH_PRIORITY = 3;
  localparam int IRQ_A_ENABLE = 2;
  localparam int IRQ_A_PENDING = 1;
  localparam int IRQ_A_EDGE_SELECT = 0;

  // Field positions of the power control register.
  localparam int COLD_START_FLAG = 4;
  localparam int USER_FLAG_HI = 3;
  localparam int USER_FLAG_LO = 2;
  localparam int DEEP_SLEEP_REQUEST = 1;
  localparam int CPU_HALT_REQUEST = 0;

  // Field positions of the auxiliary and watchdog control registers.
  localparam int STROBE_SUPPRESS = 0;
  localparam int WDOG_RUN = 7;
  localparam int WDOG_KICK = 6;
  localparam int WDOG_RUN_IN_HALT = 5;
  localparam int WDOG_DIV_SEL_LSB = 0;

  // Nibble port pins that double as the added interrupt inputs.
  localparam int PIN_IRQ_A = 2;
  localparam int PIN_IRQ_B = 3;

  // Values after reset.
  localparam logic [7:0] RESET_CTRL = 8'h00;
  localparam logic [3:0] RESET_PORT = 4'hF;
  localparam logic [7:0] RESET_READ = 8'h00;

  // Vector addresses of the two added sources.
  localparam logic [7:0] VECTOR_IRQ_A = 8'h33;
  localparam logic [7:0] VECTOR_IRQ_B = 8'h3B;
  localparam logic [7:0] VECTOR_NONE = 8'h00;

  // Watchdog timing: oscillator periods per machine cycle and timer width.
  localparam int OSC_PER_MACHINE_CYCLE = 12;
  localparam logic [3:0] MC_LAST = 4'(OSC_PER_MACHINE_CYCLE - 1);
  localparam int WDOG_TIMER_BITS = 14;

  // Power modes, Gray coded along run, halt, sleep.
  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_HALT = 2'b01,
    PWR_SLEEP = 2'b11
  } msx_power_type;
endpackage

// ---- testbench/msx_pin_model.sv ----
// Far side of the nibble port: pull-ups plus external sources that pull low.
// Assumes the device output enable means pulling the pin low.
`timescale 1ns/1ps
module msx_pin_model (
  input wire logic [3:0] pinOe,
  input wire logic [3:0] extPullLow,
  output logic [3:0] pinLevel
);
  // A pin is high unless the device or an outside source pulls it low.
  assign pinLevel = ~(pinOe | extPullLow);
endmodule

// ---- testbench/msx_sfr_tb.sv ----
// Self-checking bench for the added register block.
// Assumes one 100 MHz clock and a small watchdog timer width.
`timescale 1ns/1ps
module msx_sfr_tb;
  localparam int WB = 2;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic nPor = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWrEn = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic bitWrEn = 1'b0;
  logic [7:0] bitAddr = 8'h00;
  logic bitWrVal = 1'b0;
  logic sfrRdEn = 1'b0;
  logic sfrRmw = 1'b0;
  logic [7:0] rdData;
  logic rdHit;
  logic [3:0] pins, pinOut, pinOe;
  logic [3:0] extLow = 4'h0;
  logic ackA = 1'b0;
  logic ackB = 1'b0;
  logic wake = 1'b0;
  logic reqA, reqB, highA, highB, aleOut, halt, sleep, wdRst;
  logic [7:0] vec;
  logic aleRaw = 1'b0;
  logic extAcc = 1'b0;
  int failCount = 0;
  int testsRun = 0;
  int cyc = 0;
  logic [7:0] got;
  int n;
  int per;
  always #5 clk = ~clk;
  msx_sfr #(.WDOG_BITS(WB)) dut (.clk(clk), .nrst(nrst), .nPor(nPor), .sfrAddr(sfrAddr),
    .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .bitWrEn(bitWrEn), .bitAddr(bitAddr),
    .bitWrVal(bitWrVal), .sfrRdEn(sfrRdEn), .sfrRmw(sfrRmw), .sfrRdData_q(rdData),
    .sfrRdHit_q(rdHit), .portPinIn(pins), .portPinOut_q(pinOut), .portPinOe_q(pinOe),
    .irqAAck(ackA), .irqBAck(ackB), .coreIrqWake(wake), .irqAReq_q(reqA),
    .irqBReq_q(reqB), .irqAHigh_q(highA), .irqBHigh_q(highB), .irqVector_q(vec),
    .aleRaw(aleRaw), .extAccess(extAcc), .aleOut_q(aleOut), .cpuHalt_q(halt),
    .deepSleep_q(sleep), .wdogReset_q(wdRst));
  msx_pin_model partner (.pinOe(pinOe), .extPullLow(extLow), .pinLevel(pins));
  task automatic summarize();
    $display("Counts: %0d compared, %0d mismatched", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      failCount = failCount + 1;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    testsRun = testsRun + 1;
    if (seen !== exp) begin
      failCount = failCount + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_clk(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    @(posedge clk);
    sfrWrEn <= 1'b0;
  endtask
  task automatic bwr(input logic [7:0] a, input logic v);
    @(posedge clk);
    bitAddr <= a;
    bitWrVal <= v;
    bitWrEn <= 1'b1;
    @(posedge clk);
    bitWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic rmw);
    @(posedge clk);
    sfrAddr <= a;
    sfrRmw <= rmw;
    sfrRdEn <= 1'b1;
    @(posedge clk);
    sfrRdEn <= 1'b0;
    sfrRmw <= 1'b0;
    #1;
    got = rdData;
  endtask
  task automatic pulse_rst();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
  endtask
  logic [7:0] addrs [6] = '{8'h87, 8'h8E, 8'h8F, 8'hC0, 8'hD8, 8'h55};
  logic [7:0] exps [6] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
  logic [2:0] sels [3] = '{3'b000, 3'b010, 3'b001};
  int divs [3] = '{2, 4, 8};
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    nPor <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(addrs[i], 1'b0);
      chk("reset value", exps[i], got);
      chk("read hit", {7'h0, i < 5}, {7'h0, rdHit});
    end
    $display("Test reset values done");
    pulse_rst();
    rd(8'h87, 1'b0);
    chk("cold flag kept", 8'h10, got);
    wr(8'h87, 8'h0C);
    rd(8'h87, 1'b0);
    chk("power flags", 8'h0C, got);
    pulse_rst();
    rd(8'h87, 1'b0);
    chk("cold flag warm", 8'h00, got);
    $display("Test power flags done");
    wr(8'hC0, 8'h01);
    extLow <= 4'h4;
    wait_clk(6);
    chk("disabled request", 8'h00, {7'h0, reqA});
    rd(8'hC0, 1'b0);
    chk("edge pending", 8'h03, got);
    bwr(8'hC2, 1'b1);
    wait_clk(2);
    chk("request a", 8'h01, {7'h0, reqA});
    chk("vector a", 8'h33, vec);
    @(posedge clk);
    ackA <= 1'b1;
    @(posedge clk);
    ackA <= 1'b0;
    wait_clk(3);
    chk("serviced", 8'h00, {7'h0, reqA});
    extLow <= 4'h0;
    wr(8'hC0, 8'hC8);
    extLow <= 4'h8;
    wait_clk(6);
    chk("level b", 8'h01, {7'h0, reqB});
    chk("vector b", 8'h3B, vec);
    chk("priorities", 8'h03, {6'h0, highB, highA});
    extLow <= 4'h0;
    wait_clk(6);
    chk("level b gone", 8'h00, {7'h0, reqB});
    wr(8'hC0, 8'h44);
    extLow <= 4'hC;
    wait_clk(6);
    chk("a ranks above b", 8'h33, vec);
    extLow <= 4'h0;
    wr(8'hC0, 8'h50);
    extLow <= 4'h8;
    wait_clk(6);
    chk("edge request b", 8'h01, {7'h0, reqB});
    @(posedge clk);
    ackB <= 1'b1;
    @(posedge clk);
    ackB <= 1'b0;
    wait_clk(3);
    chk("serviced b", 8'h00, {7'h0, reqB});
    extLow <= 4'h0;
    wr(8'hC0, 8'h00);
    $display("Test interrupts done");
    wr(8'hD8, 8'h0A);
    wait_clk(2);
    chk("port out", 8'h0A, {4'h0, pinOut});
    extLow <= 4'h2;
    wait_clk(4);
    rd(8'hD8, 1'b0);
    chk("port pins", 8'hF8, got);
    rd(8'hD8, 1'b1);
    chk("port latch", 8'hFA, got);
    extLow <= 4'h0;
    wr(8'hD8, 8'h0F);
    $display("Test port done");
    wr(8'h8E, 8'h01);
    aleRaw <= 1'b1;
    wait_clk(2);
    chk("strobe off", 8'h00, {7'h0, aleOut});
    @(posedge clk);
    extAcc <= 1'b1;
    wait_clk(2);
    chk("strobe external", 8'h01, {7'h0, aleOut});
    @(posedge clk);
    extAcc <= 1'b0;
    wait_clk(2);
    chk("strobe off again", 8'h00, {7'h0, aleOut});
    wr(8'h8E, 8'h00);
    wait_clk(2);
    chk("strobe on", 8'h01, {7'h0, aleOut});
    $display("Test strobe done");
    for (int i = 0; i < 3; i++) begin
      per = 12 * divs[i] * (1 << WB);
      wr(8'h8F, {5'h08, sels[i]});
      wait_clk(14);
      rd(8'h8F, 1'b0);
      chk("kick self clears", {5'h00, sels[i]}, got);
      wr(8'h8F, {5'h10, sels[i]});
      n = 0;
      while (wdRst !== 1'b1 && n < 3000) begin
        wait_clk(1);
        n = n + 1;
      end
      chk("timeout window", 8'h01, {7'h0, n >= per - 20 && n <= per});
    end
    wr(8'h8F, 8'hC0);
    wr(8'h87, 8'h01);
    wait_clk(2);
    chk("halt", 8'h01, {7'h0, halt});
    n = 0;
    repeat (200) begin
      wait_clk(1);
      n = n + (wdRst === 1'b1);
    end
    chk("watchdog held in halt", 8'h00, 8'(n));
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    wait_clk(3);
    chk("halt woken", 8'h00, {7'h0, halt});
    wr(8'h87, 8'h02);
    wait_clk(2);
    @(posedge clk);
    wake <= 1'b1;
    repeat (3) @(posedge clk);
    wake <= 1'b0;
    #1;
    chk("sleep stays", 8'h01, {7'h0, sleep});
    pulse_rst();
    wait_clk(2);
    chk("sleep reset", 8'h00, {7'h0, sleep});
    rd(8'h8F, 1'b0);
    chk("watchdog off", 8'h00, got);
    n = 0;
    repeat (200) begin
      wait_clk(1);
      n = n + (wdRst === 1'b1);
    end
    chk("no reset when off", 8'h00, 8'(n));
    $display("Test watchdog and power done");
    summarize();
  end
endmodule
